// [rtl/anpps_pkg.sv]
package anpps_pkg;

	// ****************************************************************
	// register indices (byte address is four times the index)
	// ****************************************************************
	localparam logic [5:0] IDX_PARTNER_NEXT_PAGE_WORD   = 6'h05;
	localparam logic [5:0] IDX_AUTONEG_EXPANSION_STATUS = 6'h06;
	localparam logic [5:0] IDX_EVENT_STATUS             = 6'h08;
	localparam logic [5:0] IDX_EVENT_MASK               = 6'h09;
	localparam int         ADDR_W                       = 8;
	localparam int         BYTE_SHIFT                   = 2;

	// ****************************************************************
	// partner next page word fields
	// ****************************************************************
	localparam int         FURTHER_PAGE_REQUEST_BIT = 15;
	localparam int         PARTNER_ACK_BIT          = 14;
	localparam int         MESSAGE_FORMAT_FLAG_BIT  = 13;
	localparam int         PARTNER_COMPLY_FLAG_BIT  = 12;
	localparam int         TOGGLE_BIT               = 11;
	localparam int         CODE_MSB                 = 10;
	localparam int         WORD_W                   = 16;
	localparam logic [15:0] PARTNER_WORD_RESET      = 16'h0000;

	// ****************************************************************
	// expansion status fields
	// ****************************************************************
	localparam int         PARALLEL_DETECT_FAULT_BIT      = 4;
	localparam int         PARTNER_EXTRA_PAGE_CAPABLE_BIT = 3;
	localparam int         LOCAL_EXTRA_PAGE_CAPABLE_BIT   = 2;
	localparam int         PAGE_RECEIVED_BIT              = 1;
	localparam int         PARTNER_NEGOTIATION_CAPABLE_BIT = 0;
	localparam logic       LOCAL_EXTRA_PAGE_CAPABLE       = 1'b1;

	// ****************************************************************
	// event status / mask layout
	// ****************************************************************
	localparam int         EVT_N              = 2;
	localparam int         EVT_PAGE_RECEIVED  = 0;
	localparam int         EVT_PARALLEL_FAULT = 1;
	localparam logic [1:0] EVT_RESET          = 2'h0;

	typedef enum logic [1:0] {
		ANPPS_APB_IDLE,
		ANPPS_APB_WAIT,
		ANPPS_APB_DONE
	} anpps_apb_e;

endpackage

// [rtl/anpps_page_latch.sv]
`timescale 1ns/1ps
`default_nettype none

// holds the most recent accepted link code word as one unit
module anpps_page_latch
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        rx_word_valid,
	input  wire logic [15:0] rx_word,
	input  wire logic        rx_next_page,
	input  wire logic        negotiation_restart,
	output var  logic [15:0] held_word,
	output var  logic        held_is_next_page,
	output var  logic        accepted
);

	logic [15:0] next_held_word;
	logic        next_held_is_next_page;
	logic        take;

	// ****************************************************************
	// acceptance
	// ****************************************************************
	// once a next page is shown, a late base page must not overwrite it
	always_comb
	begin
		take = rx_word_valid && (rx_next_page || !held_is_next_page);
	end

	always_comb
	begin
		next_held_word         = held_word;
		next_held_is_next_page = held_is_next_page;
		if (negotiation_restart)
		begin
			next_held_is_next_page = 1'b0;
		end
		if (take)
		begin
			next_held_word         = rx_word;
			next_held_is_next_page = rx_next_page;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			held_word         <= anpps_pkg::PARTNER_WORD_RESET;
			held_is_next_page <= 1'b0;
		end
		else
		begin
			held_word         <= next_held_word;
			held_is_next_page <= next_held_is_next_page;
		end
	end

	assign accepted = take;

endmodule

`default_nettype wire

// [rtl/anpps_regs.sv]
`timescale 1ns/1ps
`default_nettype none

module anpps_regs
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        rx_word_valid,
	input  wire logic [15:0] rx_word,
	input  wire logic        rx_next_page,
	input  wire logic        parallel_fault_event,
	input  wire logic        negotiation_restart,
	input  wire logic        partner_extra_page_capable_in,
	input  wire logic        partner_negotiation_capable_in,
	output var  logic        irq
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic [15:0]                     partner_word;
	logic                            page_accepted;

	anpps_pkg::anpps_apb_e           apb_state;
	anpps_pkg::anpps_apb_e           next_apb_state;
	logic [31:0]                     next_prdata;
	logic                            next_pready;
	logic                            next_pslverr;
	logic                            access_done;
	logic                            wr_done;
	logic                            rd_done;
	logic [5:0]                      reg_idx;
	logic                            addr_aligned;
	logic                            hit_partner;
	logic                            hit_expansion;
	logic                            hit_status;
	logic                            hit_mask;
	logic                            mapped;
	logic [31:0]                     read_mux;

	logic                            parallel_detect_fault;
	logic                            partner_extra_page_capable;
	logic                            partner_negotiation_capable;
	logic                            page_received;
	logic                            next_parallel_detect_fault;
	logic                            next_partner_extra_page_capable;
	logic                            next_partner_negotiation_capable;
	logic                            next_page_received;
	logic [15:0]                     expansion_word;

	logic [anpps_pkg::EVT_N-1:0]     event_status;
	logic [anpps_pkg::EVT_N-1:0]     event_mask;
	logic [anpps_pkg::EVT_N-1:0]     next_event_status;
	logic [anpps_pkg::EVT_N-1:0]     next_event_mask;
	logic [anpps_pkg::EVT_N-1:0]     event_in;
	logic                            next_irq;

	// ****************************************************************
	// received page capture
	// ****************************************************************
	// the whole word is latched in one edge, so no read sees torn fields
	anpps_page_latch u_page_latch
	(
		.pclk                (pclk),
		.presetn             (presetn),
		.rx_word_valid       (rx_word_valid),
		.rx_word             (rx_word),
		.rx_next_page        (rx_next_page),
		.negotiation_restart (negotiation_restart),
		.held_word           (partner_word),
		.held_is_next_page   (),
		.accepted            (page_accepted)
	);

	// ****************************************************************
	// apb decode
	// ****************************************************************
	always_comb
	begin
		reg_idx       = paddr[anpps_pkg::ADDR_W-1:anpps_pkg::BYTE_SHIFT];
		addr_aligned  = (paddr[anpps_pkg::BYTE_SHIFT-1:0] == 2'h0);
		hit_partner   = addr_aligned && (reg_idx == anpps_pkg::IDX_PARTNER_NEXT_PAGE_WORD);
		hit_expansion = addr_aligned && (reg_idx == anpps_pkg::IDX_AUTONEG_EXPANSION_STATUS);
		hit_status    = addr_aligned && (reg_idx == anpps_pkg::IDX_EVENT_STATUS);
		hit_mask      = addr_aligned && (reg_idx == anpps_pkg::IDX_EVENT_MASK);
		mapped        = hit_partner || hit_expansion || hit_status || hit_mask;
		access_done   = psel && penable && pready;
		wr_done       = access_done && pwrite;
		rd_done       = access_done && !pwrite;
	end

	// ****************************************************************
	// expansion word assembly
	// ****************************************************************
	always_comb
	begin
		expansion_word = 16'h0000;
		expansion_word[anpps_pkg::PARALLEL_DETECT_FAULT_BIT]       = parallel_detect_fault;
		expansion_word[anpps_pkg::PARTNER_EXTRA_PAGE_CAPABLE_BIT]  = partner_extra_page_capable;
		expansion_word[anpps_pkg::LOCAL_EXTRA_PAGE_CAPABLE_BIT]    = anpps_pkg::LOCAL_EXTRA_PAGE_CAPABLE;
		expansion_word[anpps_pkg::PAGE_RECEIVED_BIT]               = page_received;
		expansion_word[anpps_pkg::PARTNER_NEGOTIATION_CAPABLE_BIT] = partner_negotiation_capable;
	end

	// ****************************************************************
	// read mux
	// ****************************************************************
	// partner word bits 15..0 pass unchanged: request, ack, format, comply, toggle, code
	always_comb
	begin
		read_mux = 32'h0000_0000;
		case (1'b1)
			hit_partner:
			begin
				read_mux[anpps_pkg::WORD_W-1:0] = partner_word;
			end
			hit_expansion:
			begin
				read_mux[anpps_pkg::WORD_W-1:0] = expansion_word;
			end
			hit_status:
			begin
				read_mux[anpps_pkg::EVT_N-1:0] = event_status;
			end
			hit_mask:
			begin
				read_mux[anpps_pkg::EVT_N-1:0] = event_mask;
			end
			default:
			begin
				read_mux = 32'h0000_0000;
			end
		endcase
	end

	// ****************************************************************
	// apb handshake
	// ****************************************************************
	// one wait state: pready is registered so every output comes from a flop
	always_comb
	begin
		next_apb_state = apb_state;
		next_pready    = 1'b0;
		next_prdata    = prdata;
		next_pslverr   = 1'b0;
		case (apb_state)
			anpps_pkg::ANPPS_APB_IDLE:
			begin
				if (psel && !penable)
				begin
					next_apb_state = anpps_pkg::ANPPS_APB_WAIT;
				end
			end
			anpps_pkg::ANPPS_APB_WAIT:
			begin
				if (psel && penable)
				begin
					next_apb_state = anpps_pkg::ANPPS_APB_DONE;
					next_pready    = 1'b1;
					next_pslverr   = !mapped;
					next_prdata    = pwrite ? 32'h0000_0000 : read_mux;
				end
			end
			anpps_pkg::ANPPS_APB_DONE:
			begin
				next_apb_state = (psel && !penable) ? anpps_pkg::ANPPS_APB_WAIT : anpps_pkg::ANPPS_APB_IDLE;
			end
			default:
			begin
				next_apb_state = anpps_pkg::ANPPS_APB_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			apb_state <= anpps_pkg::ANPPS_APB_IDLE;
			pready    <= 1'b0;
			prdata    <= 32'h0000_0000;
			pslverr   <= 1'b0;
		end
		else
		begin
			apb_state <= next_apb_state;
			pready    <= next_pready;
			prdata    <= next_prdata;
			pslverr   <= next_pslverr;
		end
	end

	// ****************************************************************
	// expansion status state
	// ****************************************************************
	// writes to the expansion and partner registers never reach these flops
	always_comb
	begin
		next_partner_extra_page_capable  = partner_extra_page_capable_in;
		next_partner_negotiation_capable = partner_negotiation_capable_in;
		next_parallel_detect_fault       = parallel_detect_fault;
		if (negotiation_restart)
		begin
			next_parallel_detect_fault = 1'b0;
		end
		if (parallel_fault_event)
		begin
			next_parallel_detect_fault = 1'b1;
		end
		next_page_received = page_received;
		if (rd_done && hit_expansion)
		begin
			next_page_received = 1'b0;
		end
		// a page landing in the same cycle as the clearing read is kept
		if (page_accepted)
		begin
			next_page_received = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			parallel_detect_fault       <= 1'b0;
			partner_extra_page_capable  <= 1'b0;
			partner_negotiation_capable <= 1'b0;
			page_received               <= 1'b0;
		end
		else
		begin
			parallel_detect_fault       <= next_parallel_detect_fault;
			partner_extra_page_capable  <= next_partner_extra_page_capable;
			partner_negotiation_capable <= next_partner_negotiation_capable;
			page_received               <= next_page_received;
		end
	end

	// ****************************************************************
	// event status, mask and interrupt
	// ****************************************************************
	always_comb
	begin
		event_in = '0;
		event_in[anpps_pkg::EVT_PAGE_RECEIVED]  = page_accepted;
		event_in[anpps_pkg::EVT_PARALLEL_FAULT] = parallel_fault_event;
	end

	genvar gi;
	generate
		for (gi = 0; gi < anpps_pkg::EVT_N; gi = gi + 1)
		begin : g_evt
			// write one to clear; a new event in the same cycle wins
			always_comb
			begin
				next_event_status[gi] = event_status[gi];
				if (wr_done && hit_status && pwdata[gi])
				begin
					next_event_status[gi] = 1'b0;
				end
				if (event_in[gi])
				begin
					next_event_status[gi] = 1'b1;
				end
				next_event_mask[gi] = event_mask[gi];
				if (wr_done && hit_mask)
				begin
					next_event_mask[gi] = pwdata[gi];
				end
			end
		end
	endgenerate

	always_comb
	begin
		next_irq = |(next_event_status & next_event_mask);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			event_status <= anpps_pkg::EVT_RESET;
			event_mask   <= anpps_pkg::EVT_RESET;
			irq          <= 1'b0;
		end
		else
		begin
			event_status <= next_event_status;
			event_mask   <= next_event_mask;
			irq          <= next_irq;
		end
	end

endmodule

`default_nettype wire

// [verif/anpps_regs_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module anpps_regs_sva
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        rx_word_valid,
	input wire logic [15:0] rx_word,
	input wire logic        rx_next_page,
	input wire logic        parallel_fault_event,
	input wire logic        negotiation_restart,
	input wire logic        partner_extra_page_capable_in,
	input wire logic        partner_negotiation_capable_in,
	input wire logic        irq
);
	// ****
	// shadow of the held partner word
	// ****
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] held;
	logic [15:0] next_held;
	logic        lock;
	logic        next_lock;
	logic        acc;
	logic        rd_pg;
	logic        rd_ex;
	logic        mapped;
	// a base page is refused once a next page is held
	assign acc    = rx_word_valid && (rx_next_page || !lock);
	assign rd_pg  = pready && !pwrite && paddr == 8'h14;
	assign rd_ex  = pready && !pwrite && paddr == 8'h18;
	assign mapped = paddr inside {8'h14, 8'h18, 8'h20, 8'h24};
	always_comb
	begin
		next_held = acc ? rx_word : held;
		// a next page taken in the restart cycle still locks, as in the latch
		next_lock = (acc && rx_next_page) || (lock && !negotiation_restart);
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			held <= 16'h0;
			lock <= 1'b0;
		end
		else
		begin
			held <= next_held;
			lock <= next_lock;
		end
	end
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable;
	endsequence
	apb_wait_a: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
		else $error("pready not after one wait state");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	bad_addr_a: assert property (pready && !mapped |-> pslverr)
		else $error("no error for bad address");
	good_addr_a: assert property (pready && mapped |-> !pslverr)
		else $error("error on mapped address");
	write_data_a: assert property (pready && pwrite |-> prdata == 32'h0)
		else $error("read data not zero on write");
	exp_reserved_a: assert property (rd_ex |-> prdata[31:5] == 27'h0)
		else $error("expansion upper bits not zero");
	local_capable_a: assert property (rd_ex |-> prdata[2])
		else $error("local capable bit not set");
	page_word_a: assert property (rd_pg |-> prdata == {16'h0, $past(held)})
		else $error("partner word mismatch");
	page_flag_a: assert property (rd_ex && $past(acc, 2) |-> prdata[1])
		else $error("page received bit missing");
	fault_flag_a: assert property (rd_ex && $past(parallel_fault_event, 2) |-> prdata[4])
		else $error("fault bit missing");
	partner_caps_a: assert property (rd_ex && $past(partner_extra_page_capable_in) ==
		$past(partner_extra_page_capable_in, 2) |-> prdata[3] == $past(partner_extra_page_capable_in))
		else $error("partner page capability wrong");
	partner_neg_a: assert property (rd_ex && $past(partner_negotiation_capable_in) ==
		$past(partner_negotiation_capable_in, 2) |-> prdata[0] == $past(partner_negotiation_capable_in))
		else $error("partner negotiation capability wrong");
endmodule
bind anpps_regs anpps_regs_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .rx_word_valid, .rx_word, .rx_next_page, .parallel_fault_event, .negotiation_restart,
	.partner_extra_page_capable_in, .partner_negotiation_capable_in, .irq);
`default_nettype wire

// [verif/anpps_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module anpps_partner
(
	input  wire logic        pclk,
	output var  logic        rx_word_valid,
	output var  logic [15:0] rx_word,
	output var  logic        rx_next_page,
	output var  logic        fault_ev,
	output var  logic        restart,
	output var  logic        np_cap,
	output var  logic        an_cap
);
	initial
	begin
		rx_word_valid = 1'b0;
		rx_word       = 16'h0;
		rx_next_page  = 1'b0;
		fault_ev      = 1'b0;
		restart       = 1'b0;
		np_cap        = 1'b0;
		an_cap        = 1'b0;
	end
	// whole word with its qualifier in one beat; stale lines are inverted after
	task automatic send(input logic [15:0] w, input logic np);
		@(posedge pclk);
		rx_word_valid <= 1'b1;
		rx_word       <= w;
		rx_next_page  <= np;
		@(posedge pclk);
		rx_word_valid <= 1'b0;
		rx_word       <= ~w;
		rx_next_page  <= ~np;
	endtask
	task automatic pulse(input logic f);
		@(posedge pclk);
		fault_ev <= f;
		restart  <= !f;
		@(posedge pclk);
		fault_ev <= 1'b0;
		restart  <= 1'b0;
	endtask
	task automatic caps(input logic n, input logic a);
		@(posedge pclk);
		np_cap <= n;
		an_cap <= a;
	endtask
endmodule
`default_nettype wire

// [verif/autoneg_partner_page_status_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module autoneg_partner_page_status_tb;
	localparam logic [7:0] A_PG = 8'h14;
	localparam logic [7:0] A_EX = 8'h18;
	localparam logic [7:0] A_EV = 8'h20;
	localparam logic [7:0] A_MK = 8'h24;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rxv;
	logic [15:0] rxw;
	logic        rxn;
	logic        fault_ev;
	logic        restart;
	logic        np_cap;
	logic        an_cap;
	logic        irq;
	int          failures;
	int          comparisons;
	anpps_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.rx_word_valid(rxv), .rx_word(rxw), .rx_next_page(rxn), .parallel_fault_event(fault_ev),
		.negotiation_restart(restart), .partner_extra_page_capable_in(np_cap),
		.partner_negotiation_capable_in(an_cap), .irq);
	anpps_partner p (.pclk, .rx_word_valid(rxv), .rx_word(rxw), .rx_next_page(rxn), .fault_ev, .restart,
		.np_cap, .an_cap);
	// ****
	// bus and compare helpers
	// ****
	task automatic complete_run;
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// holds the request until pready is seen high at an edge, giving up after 20 edges
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			chk(32'h0, 32'h1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic irq_is(input logic v);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, {31'h0, v});
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_reset;
		rd(A_PG, 32'h0);
		rd(A_EX, 32'h4);
	endtask
	task automatic t_caps;
		p.caps(1'b1, 1'b0);
		rd(A_EX, 32'hc);
		p.caps(1'b0, 1'b1);
		rd(A_EX, 32'h5);
		p.caps(1'b0, 1'b0);
	endtask
	task automatic t_pages;
		p.send(16'hd5a5, 1'b1);
		rd(A_PG, 32'hd5a5);
		rd(A_EX, 32'h6);
		rd(A_EX, 32'h4);
		p.send(16'h2a5a, 1'b1);
		p.send(16'hffff, 1'b0);
		rd(A_PG, 32'h2a5a);
		p.pulse(1'b0);
		p.send(16'h1234, 1'b0);
		rd(A_PG, 32'h1234);
		rd(A_EX, 32'h6);
	endtask
	task automatic t_writes;
		wr(A_EX, 32'hffffffff);
		rd(A_EX, 32'h4);
		wr(A_PG, 32'hffffffff);
		rd(A_PG, 32'h1234);
	endtask
	task automatic t_fault;
		p.pulse(1'b1);
		rd(A_EX, 32'h14);
		rd(A_EX, 32'h14);
		p.pulse(1'b0);
		rd(A_EX, 32'h4);
	endtask
	task automatic t_irq;
		wr(A_EV, 32'h3);
		rd(A_EV, 32'h0);
		wr(A_MK, 32'h3);
		rd(A_MK, 32'h3);
		p.send(16'h0001, 1'b1);
		irq_is(1'b1);
		rd(A_EV, 32'h1);
		wr(A_EV, 32'h1);
		irq_is(1'b0);
		wr(A_MK, 32'h2);
		p.send(16'h0002, 1'b1);
		irq_is(1'b0);
		p.pulse(1'b1);
		irq_is(1'b1);
		wr(A_EV, 32'h3);
		irq_is(1'b0);
	endtask
	task automatic t_errors;
		logic [31:0] r;
		logic        e;
		apb(1'b0, 8'h40, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		apb(1'b0, 8'h15, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
	endtask
	// a reset in mid-run must drop every held page, flag, mask and the next-page lock
	task automatic t_midreset;
		p.send(16'h5555, 1'b1);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk({31'h0, irq}, 32'h0);
		rd(A_PG, 32'h0);
		rd(A_EX, 32'h4);
		rd(A_EV, 32'h0);
		rd(A_MK, 32'h0);
		p.send(16'h0123, 1'b0);
		rd(A_PG, 32'h0123);
	endtask
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	initial
	begin
		repeat (20000) @(posedge pclk);
		failures++;
		complete_run;
	end
	initial
	begin
		failures    = 0;
		comparisons = 0;
		presetn     = 1'b0;
		psel        = 1'b0;
		penable     = 1'b0;
		pwrite      = 1'b0;
		paddr       = 8'h0;
		pwdata      = 32'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_caps;
		t_pages;
		t_writes;
		t_fault;
		t_irq;
		t_midreset;
		t_errors;
		complete_run;
	end
endmodule
`default_nettype wire
